// >>> cpr_pkg.sv
// Shared constants and types of the control-port reset and start-up block.
package cpr_pkg;
	// Fixed target address of the device on the two-wire bus.
	localparam logic [6:0] CPR_TARGET_ADDR = 7'h18;
	// System clock rate and period.
	localparam int CPR_CLK_HZ = 100000000;
	localparam int CPR_CLK_NS = 10;
	// Bus clock ceilings for standard and fast mode.
	localparam int CPR_STD_HZ = 100000;
	localparam int CPR_FAST_HZ = 400000;
	// Quarter bit periods; a least time, so rounded up.
	localparam int CPR_QTR_STD = (CPR_CLK_HZ + 4 * CPR_STD_HZ - 1) / (4 * CPR_STD_HZ);
	localparam int CPR_QTR_FAST = (CPR_CLK_HZ + 4 * CPR_FAST_HZ - 1) / (4 * CPR_FAST_HZ);
	// Least low time of the reset pin, rounded up to whole cycles.
	localparam int CPR_RST_PULSE_NS = 10;
	localparam int CPR_RST_PULSE_CYC = (CPR_RST_PULSE_NS + CPR_CLK_NS - 1) / CPR_CLK_NS;
	// Memory initialization after reset; a longest time, rounded down.
	localparam int CPR_INIT_US = 1000;
	localparam int CPR_INIT_CYC = (CPR_INIT_US * 1000) / CPR_CLK_NS;
	// Clock multiplier settling time before codec clocks are released.
	localparam int CPR_PLL_MS = 10;
	localparam int CPR_PLL_CYC = (CPR_PLL_MS * 1000000) / CPR_CLK_NS;
	// Device register indices, field positions and reset value.
	localparam logic [7:0] CPR_REG_PAGE = 8'h00;
	localparam logic [7:0] CPR_REG_SOFT_RESET = 8'h01;
	localparam logic [7:0] CPR_REG_POWER = 8'h02;
	localparam logic [7:0] CPR_REG_STATUS = 8'h03;
	localparam logic [7:0] CPR_REG_RESET = 8'h00;
	localparam int CPR_SOFT_RESET_BIT = 0;
	localparam int CPR_PWR_PLL_BIT = 0;
	localparam int CPR_PWR_CODEC_BIT = 1;
	// Host APB register byte addresses and fields.
	localparam int CPR_APB_AW = 12;
	localparam logic [11:0] CPR_HOST_CTRL = 12'h000;
	localparam logic [11:0] CPR_HOST_CMD = 12'h004;
	localparam logic [11:0] CPR_HOST_STATUS = 12'h008;
	localparam logic [11:0] CPR_HOST_RDATA = 12'h00C;
	localparam int CPR_CTRL_GO = 0;
	localparam int CPR_CTRL_FAST = 1;
	localparam int CPR_CTRL_RST = 2;
	localparam int CPR_CMD_READ = 16;
	localparam int CPR_ST_BUSY = 0;
	localparam int CPR_ST_NACK = 1;
	localparam int CPR_ST_RSTACT = 2;
	// Target bus states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_ADDR = 3'h1,
		DS_ADDR_ACK = 3'h3,
		DS_WDATA = 3'h2,
		DS_WACK = 3'h6,
		DS_RDATA = 3'h7,
		DS_RACK = 3'h5
	} cpr_dstate_t;
	// Controller states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_RST = 3'h1,
		HS_WAIT = 3'h3,
		HS_START = 3'h2,
		HS_FRAME = 3'h6,
		HS_STOP = 3'h7
	} cpr_hstate_t;
endpackage : cpr_pkg

// >>> cpr_link_if.sv
// Two-wire link and reset pin between host controller and device target.
`timescale 1ns/1ns
interface cpr_link_if;
	// Open-drain drivers: enable low means the line is pulled to the output value.
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	// Active-low hardware reset pin, driven by the host.
	logic reset_pin_n;
	// Resolved wire levels with pull-ups.
	logic scl;
	logic sda;
	assign scl = ~(~host_scl_oe_n & ~host_scl_o);
	assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
	modport device (input scl, input sda, input reset_pin_n, output dev_sda_o, output dev_sda_oe_n);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o,
		output host_sda_oe_n, output reset_pin_n);
endinterface : cpr_link_if

// >>> cpr_device.sv
// Device end: two-wire target, register file, reset, init lockout and clock start-up delay.
`timescale 1ns/1ns

// Behaviour
// - Answer only target address 0011000.
// - Target only; never drive the bus clock.
// - Registers are eight bits; writes read back, except at the read-only status register and the self-clearing reset bit.
// - Pointer advances after each data byte.
// - Works at standard and fast bus rates.
// - All control reachable through bus registers.
// - Any reset restores all default state.
// - Host holds reset pin low 10 ns.
// - Page 0 register 1 bit 0 resets.
// - Memory initialization finishes within 1 ms.
// - Host avoids coefficient access during initialization; the host waits only after pin and software resets, not after a system reset.
// - Host powers nothing during initialization; after a system reset the host starts idle and takes orders at once.
// - Withhold codec clocks 10 ms after multiplier on.
// - Blocks start powered down after reset.
module cpr_device import cpr_pkg::*; #(
	parameter int NREG = 8,
	parameter int INIT_CYCLES = CPR_INIT_CYC,
	parameter int PLL_CYCLES = CPR_PLL_CYC
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	cpr_link_if.device lnk,
	output logic init_busy_o,
	output logic codec_clk_en_o,
	output logic pll_power_o,
	output logic codec_power_o,
	output logic [7:0] page_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Sizes and state.

	// Counter width covers the longer of the two start-up intervals.
	localparam int CW = $clog2((PLL_CYCLES > INIT_CYCLES ? PLL_CYCLES : INIT_CYCLES) + 1);
	// Index width into the register store.
	localparam int IW = $clog2(NREG);

	// All state of the device in one record.
	typedef struct packed {
		cpr_dstate_t st; // Bus protocol state.
		logic scl_q; // Previous clock level, for edge detection.
		logic sda_q; // Previous data level, for start and stop detection.
		logic [3:0] cnt; // Bit count within the current byte.
		logic [7:0] sh; // Shift register for incoming and outgoing bytes.
		logic rw; // Direction bit of the current address byte.
		logic first; // The next written byte is the register pointer.
		logic pull; // Pull the data line low.
		logic go; // The last read byte was acknowledged.
		logic rst_req; // Software reset requested, applied after the acknowledge.
		logic [7:0] ptr; // Register pointer.
		logic [NREG-1:0][7:0] regs; // Register store.
		logic [CW-1:0] init_cnt; // Remaining initialization cycles.
		logic [CW-1:0] pll_cnt; // Remaining multiplier settling cycles.
		logic clk_rdy; // Codec clocks released.
	} cpr_dev_state_t;

	cpr_dev_state_t s; // Registered state.
	cpr_dev_state_t n; // Next state.
	cpr_dev_state_t dflt; // Default state after any reset.
	logic scl_rise; // Bus clock rising edge.
	logic scl_fall; // Bus clock falling edge.
	logic start_seen; // Start or repeated start condition.
	logic stop_seen; // Stop condition.
	logic [7:0] rd_val; // Byte at the register pointer.
	logic wr_ok; // The pointer names a writable register.

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Builds the default state; every register takes its reset value.
	function automatic cpr_dev_state_t cpr_dev_defaults();
		cpr_dev_state_t d;
		d = '0;
		d.st = DS_IDLE;
		d.scl_q = 1'b1;
		d.sda_q = 1'b1;
		for (int i = 0; i < NREG; i++) begin
			d.regs[i] = CPR_REG_RESET;
		end
		d.init_cnt = CW'(INIT_CYCLES);
		d.pll_cnt = CW'(PLL_CYCLES);
		return d;
	endfunction : cpr_dev_defaults

	// Returns the byte that a read at an index shows; unmapped indices read zero.
	function automatic logic [7:0] cpr_read(input cpr_dev_state_t v, input logic [7:0] idx);
		logic [7:0] b;
		b = 8'h00;
		if (idx == CPR_REG_STATUS) begin
			b = {6'h00, v.clk_rdy, v.init_cnt != '0};
		end else if (int'(idx) < NREG) begin
			b = v.regs[idx[IW-1:0]];
		end
		return b;
	endfunction : cpr_read

	assign dflt = cpr_dev_defaults();
	assign rd_val = cpr_read(s, s.ptr);
	// The status register is read-only; everything else in range stores writes.
	assign wr_ok = (int'(s.ptr) < NREG) && (s.ptr != CPR_REG_STATUS);

	// Line inputs are synchronous to mclk, so edges come straight from one stored copy.
	// The sampling rate far exceeds either bus rate, so both modes are seen alike.
	assign scl_rise = lnk.scl & ~s.scl_q;
	assign scl_fall = ~lnk.scl & s.scl_q;
	assign start_seen = lnk.scl & s.scl_q & s.sda_q & ~lnk.sda;
	assign stop_seen = lnk.scl & s.scl_q & ~s.sda_q & lnk.sda;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Protocol engine, start-up timers and reset, all in one pass.
	always_comb begin
		n = s;
		n.scl_q = lnk.scl;
		n.sda_q = lnk.sda;
		// Initialization counts down from any reset; the lockout shows in status.
		if (s.init_cnt != '0) begin
			n.init_cnt = s.init_cnt - 1'b1;
		end
		// Codec clocks stay off until the multiplier has been on for the full delay.
		if (!s.regs[CPR_REG_POWER][CPR_PWR_PLL_BIT]) begin
			n.pll_cnt = CW'(PLL_CYCLES);
			n.clk_rdy = 1'b0;
		end else if (s.pll_cnt != '0) begin
			n.pll_cnt = s.pll_cnt - 1'b1;
		end else begin
			n.clk_rdy = 1'b1;
		end
		if (stop_seen) begin
			// A stop ends any transfer and frees the data line.
			n.st = DS_IDLE;
			n.pull = 1'b0;
		end else if (start_seen) begin
			// A start, repeated or not, begins a new address byte.
			n.st = DS_ADDR;
			n.cnt = 4'h0;
			n.pull = 1'b0;
			n.first = 1'b1;
		end else begin
			unique case (s.st)
				DS_IDLE: begin
					// Nothing to do until a start.
				end
				DS_ADDR: begin
					if (scl_rise) begin
						n.sh = {s.sh[6:0], lnk.sda};
						n.cnt = s.cnt + 4'h1;
					end else if (scl_fall && s.cnt == 4'h8) begin
						if (s.sh[7:1] == CPR_TARGET_ADDR) begin
							n.pull = 1'b1;
							n.rw = s.sh[0];
							n.st = DS_ADDR_ACK;
						end else begin
							n.st = DS_IDLE;
						end
					end
				end
				DS_ADDR_ACK: begin
					if (scl_fall) begin
						n.cnt = 4'h0;
						if (s.rw) begin
							// First read byte comes from the current pointer.
							n.sh = rd_val;
							n.pull = ~rd_val[7];
							n.st = DS_RDATA;
						end else begin
							n.pull = 1'b0;
							n.st = DS_WDATA;
						end
					end
				end
				DS_WDATA: begin
					if (scl_rise) begin
						n.sh = {s.sh[6:0], lnk.sda};
						n.cnt = s.cnt + 4'h1;
					end else if (scl_fall && s.cnt == 4'h8) begin
						n.pull = 1'b1;
						n.st = DS_WACK;
						if (s.first) begin
							// The first byte after the address sets the pointer.
							n.ptr = s.sh;
							n.first = 1'b0;
						end else begin
							n.ptr = s.ptr + 8'h01;
							if (wr_ok) begin
								n.regs[s.ptr[IW-1:0]] = s.sh;
							end
							// Resetting is deferred so that the acknowledge still goes out.
							if (s.ptr == CPR_REG_SOFT_RESET && s.sh[CPR_SOFT_RESET_BIT] &&
								s.regs[CPR_REG_PAGE] == 8'h00) begin
								n.rst_req = 1'b1;
							end
						end
					end
				end
				DS_WACK: begin
					if (scl_fall) begin
						n.pull = 1'b0;
						n.cnt = 4'h0;
						n.st = DS_WDATA;
						if (s.rst_req) begin
							// Defaults hold a cleared reset bit, so it reads zero afterwards.
							n = dflt;
						end
					end
				end
				DS_RDATA: begin
					if (scl_rise) begin
						n.cnt = s.cnt + 4'h1;
					end else if (scl_fall) begin
						if (s.cnt == 4'h8) begin
							// Release the line for the controller's acknowledge.
							n.pull = 1'b0;
							n.st = DS_RACK;
						end else begin
							n.sh = {s.sh[6:0], 1'b0};
							n.pull = ~s.sh[6];
						end
					end
				end
				DS_RACK: begin
					if (scl_rise) begin
						// Every byte read moves the pointer on, the refused last one too.
						n.ptr = s.ptr + 8'h01;
						if (lnk.sda) begin
							// A refusal ends the read; wait for stop or start.
							n.st = DS_IDLE;
						end else begin
							n.go = 1'b1;
						end
					end else if (scl_fall && s.go) begin
						n.go = 1'b0;
						n.cnt = 4'h0;
						n.sh = rd_val;
						n.pull = ~rd_val[7];
						n.st = DS_RDATA;
					end
				end
				default: begin
					n.st = DS_IDLE;
				end
			endcase
		end
		// Pin or system reset: everything, power control included, to defaults.
		if (!reset_n_i || !lnk.reset_pin_n) begin
			n = dflt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// The reset is folded into the next value, so this stays a plain register.
	always_ff @(posedge mclk_i) begin
		s <= n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	// The device only ever pulls data; it has no clock driver at all.
	assign lnk.dev_sda_o = 1'b0;
	assign lnk.dev_sda_oe_n = ~s.pull;
	assign init_busy_o = s.init_cnt != '0;
	assign codec_clk_en_o = s.clk_rdy;
	// Power bits default to zero, so every block starts powered down.
	assign pll_power_o = s.regs[CPR_REG_POWER][CPR_PWR_PLL_BIT];
	assign codec_power_o = s.regs[CPR_REG_POWER][CPR_PWR_CODEC_BIT];
	assign page_o = s.regs[CPR_REG_PAGE];

endmodule : cpr_device

// >>> cpr_host.sv
// Host end: APB-controlled two-wire bus controller and reset pin driver.
`timescale 1ns/1ns
module cpr_host import cpr_pkg::*; #(
	parameter int INIT_CYCLES = CPR_INIT_CYC
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [CPR_APB_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	cpr_link_if.host lnk
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	localparam int CW = $clog2(INIT_CYCLES + 1);

	// All state of the controller in one record.
	typedef struct packed {
		cpr_hstate_t st; // Controller state.
		logic [1:0] q; // Quarter of the current bit.
		logic [7:0] tick; // Cycles left in the quarter.
		logic [2:0] step; // Position in the transfer.
		logic [3:0] bitn; // Bit within the nine-bit frame.
		logic [8:0] tx; // Frame to send, acknowledge slot last.
		logic [8:0] rx; // Frame as seen on the line.
		logic scl; // Clock released when high.
		logic sda; // Data released when high.
		logic fast; // Fast-mode bus rate.
		logic [7:0] cmd_reg; // Target register index.
		logic [7:0] cmd_data; // Byte to write.
		logic cmd_rd; // Read instead of write.
		logic nack; // Last transfer was refused.
		logic [7:0] rdata; // Last byte read.
		logic [CW-1:0] wcnt; // Reset pulse and lockout counter.
		logic rst_pin; // Reset pin level.
		logic [31:0] prdata; // Read data for the access phase.
	} cpr_host_state_t;

	cpr_host_state_t s; // Registered state.
	cpr_host_state_t n; // Next state.
	logic qtick; // End of a quarter bit.
	logic [7:0] qload; // Quarter length for the selected rate.
	logic apb_wr; // Write access phase.
	logic soft_rst_cmd; // The pending write fires the device's software reset.

	// Decodes whether an APB address names one of the controller's registers.
	function automatic logic cpr_hit(input logic [CPR_APB_AW-1:0] a);
		return a == CPR_HOST_CTRL || a == CPR_HOST_CMD || a == CPR_HOST_STATUS || a == CPR_HOST_RDATA;
	endfunction : cpr_hit

	assign qload = s.fast ? 8'(CPR_QTR_FAST - 1) : 8'(CPR_QTR_STD - 1);
	assign qtick = s.tick == 8'h00;
	assign apb_wr = psel_i & penable_i & pwrite_i;
	assign soft_rst_cmd = !s.cmd_rd && s.cmd_reg == CPR_REG_SOFT_RESET && s.cmd_data[CPR_SOFT_RESET_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Register bus, bus sequencer and reset pin sequencing.
	always_comb begin
		n = s;
		// Read data is taken in the setup cycle, so the access phase needs no wait.
		if (psel_i && !penable_i) begin
			unique case (paddr_i)
				CPR_HOST_CTRL: n.prdata = {30'h0, s.fast, 1'b0};
				CPR_HOST_CMD: n.prdata = {15'h0, s.cmd_rd, s.cmd_data, s.cmd_reg};
				CPR_HOST_STATUS: n.prdata = {29'h0, s.st == HS_RST || s.st == HS_WAIT, s.nack, s.st != HS_IDLE};
				CPR_HOST_RDATA: n.prdata = {24'h0, s.rdata};
				default: n.prdata = 32'h0;
			endcase
		end
		// Orders are taken only while idle, so a running transfer cannot be corrupted.
		if (apb_wr && s.st == HS_IDLE) begin
			if (paddr_i == CPR_HOST_CTRL) begin
				n.fast = pwdata_i[CPR_CTRL_FAST];
				if (pwdata_i[CPR_CTRL_RST]) begin
					n.st = HS_RST;
					n.rst_pin = 1'b0;
					n.wcnt = CW'(CPR_RST_PULSE_CYC);
				end else if (pwdata_i[CPR_CTRL_GO]) begin
					n.st = HS_START;
					n.step = 3'h0;
					n.q = 2'h0;
					// The rate being written times the first quarter too, not the rate it replaces.
					n.tick = pwdata_i[CPR_CTRL_FAST] ? 8'(CPR_QTR_FAST - 1) : 8'(CPR_QTR_STD - 1);
					n.nack = 1'b0;
				end
			end else if (paddr_i == CPR_HOST_CMD) begin
				n.cmd_reg = pwdata_i[7:0];
				n.cmd_data = pwdata_i[15:8];
				n.cmd_rd = pwdata_i[CPR_CMD_READ];
			end
		end
		unique case (s.st)
			HS_IDLE: begin
				// Waiting for an order.
			end
			HS_RST: begin
				// Hold the pin low for the least pulse width, then start the lockout.
				if (s.wcnt > CW'(1)) begin
					n.wcnt = s.wcnt - 1'b1;
				end else begin
					n.rst_pin = 1'b1;
					n.wcnt = CW'(INIT_CYCLES);
					n.st = HS_WAIT;
				end
			end
			HS_WAIT: begin
				// No access and no power-up while the device initializes its memories.
				if (s.wcnt != '0) begin
					n.wcnt = s.wcnt - 1'b1;
				end else begin
					n.st = HS_IDLE;
				end
			end
			default: begin
				// The three bus states run on quarter-bit ticks.
				if (!qtick) begin
					n.tick = s.tick - 8'h01;
				end else begin
					n.tick = qload;
					n.q = s.q + 2'h1;
					if (s.st == HS_START) begin
						// Start works from either clock level, so it also serves as repeat.
						unique case (s.q)
							2'h0: n.sda = 1'b1;
							2'h1: n.scl = 1'b1;
							2'h2: n.sda = 1'b0;
							default: begin
								n.scl = 1'b0;
								n.tx = {CPR_TARGET_ADDR, s.step != 3'h0, 1'b1};
								n.bitn = 4'h0;
								n.st = HS_FRAME;
							end
						endcase
					end else if (s.st == HS_FRAME) begin
						unique case (s.q)
							2'h0: n.sda = s.tx[8];
							2'h1: n.scl = 1'b1;
							2'h2: n.rx = {s.rx[7:0], lnk.sda};
							default: begin
								n.scl = 1'b0;
								n.tx = {s.tx[7:0], 1'b1};
								n.bitn = s.bitn + 4'h1;
								if (s.bitn == 4'h8) begin
									n.bitn = 4'h0;
									if (s.step == 3'h4) begin
										n.rdata = s.rx[8:1];
										n.st = HS_STOP;
									end else if (s.rx[0]) begin
										n.nack = 1'b1;
										n.st = HS_STOP;
									end else if (s.step == 3'h0) begin
										n.step = 3'h1;
										n.tx = {s.cmd_reg, 1'b1};
									end else if (s.step == 3'h1 && s.cmd_rd) begin
										n.step = 3'h2;
										n.st = HS_START;
									end else if (s.step == 3'h1) begin
										n.step = 3'h3;
										n.tx = {s.cmd_data, 1'b1};
									end else if (s.step == 3'h2) begin
										// Read frame releases all nine bits, ending with a refusal.
										n.step = 3'h4;
										n.tx = 9'h1FF;
									end else begin
										n.st = HS_STOP;
									end
								end
							end
						endcase
					end else begin
						unique case (s.q)
							2'h0: n.sda = 1'b0;
							2'h1: n.scl = 1'b1;
							2'h2: n.sda = 1'b1;
							default: begin
								// A software reset locks the host out just as the pin does.
								if (soft_rst_cmd && !s.nack) begin
									n.wcnt = CW'(INIT_CYCLES);
									n.st = HS_WAIT;
								end else begin
									n.st = HS_IDLE;
								end
							end
						endcase
					end
				end
			end
		endcase
		if (!reset_n_i) begin
			n = '0;
			n.st = HS_IDLE;
			n.scl = 1'b1;
			n.sda = 1'b1;
			n.rst_pin = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register and outputs.

	// Reset is folded into the next value.
	always_ff @(posedge mclk_i) begin
		s <= n;
	end

	// The controller owns the bus clock; both lines are open drain.
	assign lnk.host_scl_o = 1'b0;
	assign lnk.host_scl_oe_n = s.scl;
	assign lnk.host_sda_o = 1'b0;
	assign lnk.host_sda_oe_n = s.sda;
	assign lnk.reset_pin_n = s.rst_pin;
	assign prdata_o = s.prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~cpr_hit(paddr_i);

endmodule : cpr_host

// >>> cpr_check_sva.sv
// Checker for reset, start-up lockout, clock release and link drive timing.
`timescale 1ns/1ns
module cpr_check #(
	parameter int INIT_CYCLES = 20,
	parameter int PLL_CYCLES = 50
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic scl,
	input wire logic reset_pin_n,
	input wire logic dev_sda_oe_n,
	input wire logic init_busy_o,
	input wire logic codec_clk_en_o,
	input wire logic pll_power_o,
	input wire logic codec_power_o,
	input wire logic [7:0] page_o
);
	// Upper bound on the initialization wait after the pin is released.
	localparam int INIT_HI = INIT_CYCLES + 3;
	// Cycles the multiplier has been powered; it saturates so it never wraps.
	int pll_cnt;
	////////////////////////////////////////////////////////////////
	// Counter of the multiplier power-on time.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i || !pll_power_o) begin
			pll_cnt <= 0;
		end else if (pll_cnt < PLL_CYCLES + 8) begin
			pll_cnt <= pll_cnt + 1;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////
	property p_pin_reset;
		!reset_pin_n |=> init_busy_o && dev_sda_oe_n && !pll_power_o && !codec_power_o && !codec_clk_en_o
			&& page_o == 8'h00;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset left state behind");
	property p_pulse;
		$fell(reset_pin_n) |=> reset_pin_n;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
	property p_init_hold;
		$rose(reset_pin_n) |-> init_busy_o [*8];
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("init ended too soon");
	property p_init_end;
		$rose(reset_pin_n) |-> ##[1:INIT_HI] !init_busy_o;
	endproperty
	a_init_end: assert property (p_init_end) else $error("init too long");
	property p_soft_clear;
		$rose(init_busy_o) |-> !pll_power_o && !codec_power_o && page_o == 8'h00;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("reset kept register state");
	property p_clk_early;
		codec_clk_en_o |-> pll_cnt >= PLL_CYCLES - 1;
	endproperty
	a_clk_early: assert property (p_clk_early) else $error("codec clocks released early");
	property p_clk_late;
		pll_cnt >= PLL_CYCLES + 3 |-> codec_clk_en_o;
	endproperty
	a_clk_late: assert property (p_clk_late) else $error("codec clocks released late");
	property p_clk_drop;
		$fell(pll_power_o) |=> !codec_clk_en_o;
	endproperty
	a_clk_drop: assert property (p_clk_drop) else $error("codec clocks kept after power off");
	property p_sda_edge;
		$changed(dev_sda_oe_n) && $past(reset_pin_n) |-> !scl;
	endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("target moved data while clock high");
	c_soft: cover property ($rose(init_busy_o));
	c_clk: cover property ($rose(codec_clk_en_o));
	c_ack: cover property ($fell(dev_sda_oe_n));
endmodule : cpr_check

// >>> cpr_tb.sv
// Testbench joining host and device ends over the link, driven through APB.
`timescale 1ns/1ns
module testbench import cpr_pkg::*;;
	localparam int INIT_N = 20;
	localparam int PLL_N = 1000;
	logic mclk_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic init_busy, codec_clk_en, pll_power, codec_power;
	logic [7:0] page;
	int fails, cmp_count;
	cpr_link_if cpr_link_if_inst ();
	cpr_host #(.INIT_CYCLES(INIT_N)) cpr_host_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .lnk(cpr_link_if_inst));
	cpr_device #(.NREG(8), .INIT_CYCLES(INIT_N), .PLL_CYCLES(PLL_N)) cpr_device_inst (.mclk_i(mclk_i),
		.reset_n_i(reset_n_i), .lnk(cpr_link_if_inst), .init_busy_o(init_busy), .codec_clk_en_o(codec_clk_en),
		.pll_power_o(pll_power), .codec_power_o(codec_power), .page_o(page));
	cpr_check #(.INIT_CYCLES(INIT_N), .PLL_CYCLES(PLL_N)) cpr_check_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.scl(cpr_link_if_inst.scl), .reset_pin_n(cpr_link_if_inst.reset_pin_n),
		.dev_sda_oe_n(cpr_link_if_inst.dev_sda_oe_n), .init_busy_o(init_busy), .codec_clk_en_o(codec_clk_en),
		.pll_power_o(pll_power), .codec_power_o(codec_power), .page_o(page));
	////////////////////////////////////////////////////////////////
	// Free-running system clock.
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One APB transfer; the request stands until pready is seen high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			fails++;
			stop_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
	endtask : rd
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	// Polls the host until it is idle; the bound covers the longest frame.
	task wait_idle(output logic [31:0] st);
		int n;
		n = 0;
		do begin
			rd(CPR_HOST_STATUS, st);
			n++;
		end while (st[CPR_ST_BUSY] !== 1'b0 && n < 8000);
		if (st[CPR_ST_BUSY] !== 1'b0) begin
			fails++;
			stop_test();
		end
	endtask : wait_idle
	// One fast-mode device register access through the host.
	task xfer(input logic r, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
		logic [31:0] st;
		wait_idle(st);
		wr(CPR_HOST_CMD, {15'h0000, r, d, idx});
		wr(CPR_HOST_CTRL, 32'h0000_0003);
		wait_idle(st);
		chk("nack", 32'(st[CPR_ST_NACK]), 32'h0000_0000);
		rd(CPR_HOST_RDATA, st);
		q = st[7:0];
	endtask : xfer
	////////////////////////////////////////////////////////////////
	task s_readback;
		logic [7:0] q;
		logic [31:0] v;
		logic e;
		xfer(1'b0, 8'h07, 8'hA5, q);
		xfer(1'b1, 8'h07, 8'h00, q);
		chk("reg7", 32'(q), 32'h0000_00A5);
		apb(1'b0, 12'h010, 32'h0000_0000, v, e);
		chk("slverr", 32'(e), 32'h0000_0001);
	endtask : s_readback
	task s_pll;
		logic [7:0] q;
		chk("pll_off", 32'(pll_power), 32'h0000_0000);
		xfer(1'b0, CPR_REG_POWER, 8'h01, q);
		chk("clk_early", 32'(codec_clk_en), 32'h0000_0000);
		repeat (PLL_N) @(posedge mclk_i);
		chk("clk_on", 32'(codec_clk_en), 32'h0000_0001);
		xfer(1'b1, CPR_REG_STATUS, 8'h00, q);
		chk("status", 32'(q), 32'h0000_0002);
		xfer(1'b0, CPR_REG_POWER, 8'h02, q);
		chk("clk_off", 32'(codec_clk_en), 32'h0000_0000);
		chk("codec_on", 32'(codec_power), 32'h0000_0001);
	endtask : s_pll
	task s_pin;
		logic [7:0] q;
		wr(CPR_HOST_CTRL, 32'h0000_0004);
		repeat (2) @(posedge mclk_i);
		chk("busy", 32'(init_busy), 32'h0000_0001);
		chk("codec_rst", 32'(codec_power), 32'h0000_0000);
		repeat (INIT_N + 4) @(posedge mclk_i);
		chk("idle", 32'(init_busy), 32'h0000_0000);
		xfer(1'b1, 8'h07, 8'h00, q);
		chk("reg7_rst", 32'(q), 32'h0000_0000);
	endtask : s_pin
	task s_soft;
		logic [7:0] q;
		xfer(1'b0, 8'h04, 8'h77, q);
		xfer(1'b0, CPR_REG_SOFT_RESET, 8'h01, q);
		xfer(1'b1, 8'h04, 8'h00, q);
		chk("reg4_rst", 32'(q), 32'h0000_0000);
		xfer(1'b1, CPR_REG_SOFT_RESET, 8'h00, q);
		chk("soft_bit", 32'(q), 32'h0000_0000);
	endtask : s_soft
	// Standard rate: the start drops the clock after four 250-cycle quarters; a mid-run reset then aborts.
	task s_std;
		logic [31:0] st;
		wait_idle(st);
		wr(CPR_HOST_CTRL, 32'h0000_0001);
		repeat (4 * CPR_QTR_STD - 8) @(posedge mclk_i);
		chk("std_hi", 32'(cpr_link_if_inst.scl), 32'h0000_0001);
		repeat (16) @(posedge mclk_i);
		chk("std_lo", 32'(cpr_link_if_inst.scl), 32'h0000_0000);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		@(posedge mclk_i);
		chk("rst_busy", 32'({init_busy, cpr_link_if_inst.scl}), 32'h0000_0003);
	endtask : s_std
	// Main sequence: reset, then each scenario in turn.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		fails = 0;
		cmp_count = 0;
		reset_n_i = 1'b0;
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		@(posedge mclk_i);
		chk("init_busy", 32'(init_busy), 32'h0000_0001);
		s_readback();
		s_pll();
		s_pin();
		s_soft();
		s_std();
		stop_test();
	end
endmodule : testbench
